// >>> design/nvm_ctl.sv
`timescale 1ns/1ps
`include "nvm_ctl_regs.svh"
module nvm_ctl
  import nvm_ctl_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int ERASE_CYC = `ERASE_CYC,
  parameter int PROG_CYC = `PROG_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por,
  input wire logic pwrt_active,
  input wire sfr_req_t req,
  output logic [7:0] rdata,
  output logic flash_start,
  output logic flash_row_erase,
  output logic cfg_target,
  output logic busy
);

  ////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic pwrt_s1_r;
  logic pwrt_s2_r;

  always_ff @(posedge clk_sys) begin
    if (por) begin
      pwrt_s1_r <= 1'b1;
      pwrt_s2_r <= 1'b1;
    end else begin
      pwrt_s1_r <= pwrt_active;
      pwrt_s2_r <= pwrt_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State
  logic msel_r, msel_nxt;
  logic csel_r, csel_nxt;
  logic free_r, free_nxt;
  logic abort_r, abort_nxt;
  logic gate_r, gate_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic done_r, done_nxt;
  logic [7:0] adl_r, adl_nxt;
  logic [1:0] adh_r, adh_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic flash_r, flash_nxt;
  logic ext_r, ext_nxt;
  wr_state_t ws_r, ws_nxt;
  unlock_t ul_r, ul_nxt;
  logic [7:0] mem_r [DEPTH];
  logic mem_we;
  logic [7:0] mem_wd;
  logic [9:0] addr;
  logic sw;
  logic go_wr;
  logic go_rd;

  function automatic logic hit(input sfr_req_t r, input logic [2:0] idx);
    return r.wr && (r.sel == idx);
  endfunction

  assign addr = {adh_r, adl_r}; // RQ3
  assign sw = hit(req, `IDX_CONTROL);

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    msel_nxt = msel_r;
    csel_nxt = csel_r;
    free_nxt = free_r;
    abort_nxt = abort_r;
    gate_nxt = gate_r;
    wr_nxt = wr_r;
    rd_nxt = 1'b0; // RQ12
    done_nxt = done_r;
    adl_nxt = adl_r;
    adh_nxt = adh_r;
    data_nxt = data_r;
    tmr_nxt = tmr_r;
    ws_nxt = ws_r;
    ul_nxt = ul_r;
    flash_nxt = 1'b0;
    ext_nxt = ext_r;
    mem_we = 1'b0;
    mem_wd = data_r;
    go_wr = 1'b0;
    go_rd = 1'b0;

    // Unlock sequencer; any other write breaks it
    if (req.wr) begin
      ul_nxt = UL_IDLE; // RQ18
      if (req.sel == `IDX_UNLOCK) begin
        if (req.wdata == `UNLOCK_KEY1) begin
          ul_nxt = UL_KEY1;
        end else if (req.wdata == `UNLOCK_KEY2 && ul_r == UL_KEY1) begin
          ul_nxt = UL_KEY2;
        end
      end
    end

    if (ws_r == WS_IDLE) begin // RQ20
      if (sw) begin
        msel_nxt = req.wdata[`BIT_MSEL];
        csel_nxt = req.wdata[`BIT_CSEL];
        free_nxt = req.wdata[`BIT_FREE];
        abort_nxt = req.wdata[`BIT_ABORT];
        gate_nxt = req.wdata[`BIT_GATE];
        if (req.wdata[`BIT_RD] && !req.wdata[`BIT_MSEL]
            && !req.wdata[`BIT_CSEL]) begin
          go_rd = 1'b1; // RQ11
        end
        if (req.wdata[`BIT_WR]) begin
          // Gate must already be open, unlock done, timer expired
          if (gate_r && ul_r == UL_KEY2 && !pwrt_s2_r) begin
            go_wr = 1'b1; // RQ6 RQ18 RQ19 RQ21
          end else begin
            abort_nxt = 1'b1; // RQ8
          end
        end
      end
      if (hit(req, `IDX_ADDR_LO)) begin
        adl_nxt = req.wdata;
      end
      if (hit(req, `IDX_ADDR_HI)) begin
        adh_nxt = req.wdata[1:0];
      end
      if (hit(req, `IDX_DATA)) begin
        data_nxt = req.wdata; // RQ13
      end
    end

    if (go_rd) begin
      rd_nxt = 1'b1;
      data_nxt = mem_r[addr]; // RQ4 RQ12
    end

    case (ws_r)
      WS_IDLE: begin
        if (go_wr) begin
          wr_nxt = 1'b1; // RQ9
          abort_nxt = 1'b1; // RQ7
          ext_nxt = msel_nxt | csel_nxt; // RQ1 RQ2
          flash_nxt = msel_nxt | csel_nxt;
          tmr_nxt = 32'(ERASE_CYC - 1); // RQ22
          ws_nxt = WS_ERASE;
        end
      end
      WS_ERASE: begin
        if (tmr_r == 32'h0) begin
          if (!ext_r) begin
            mem_we = 1'b1; // RQ5
            mem_wd = `ERASED_BYTE;
          end
          tmr_nxt = 32'(PROG_CYC - 1);
          ws_nxt = WS_PROG;
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      WS_PROG: begin
        if (tmr_r == 32'h0) begin
          mem_we = !ext_r; // RQ5
          wr_nxt = 1'b0; // RQ9
          abort_nxt = 1'b0; // RQ7
          free_nxt = 1'b0; // RQ16
          done_nxt = 1'b1; // RQ10
          ws_nxt = WS_IDLE;
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      default: begin
        ws_nxt = WS_IDLE;
      end
    endcase

    // Software clear of done; completion wins
    if (hit(req, `IDX_FLAGS2) && !req.wdata[`BIT_DONE]
        && !(ws_r == WS_PROG && tmr_r == 32'h0)) begin
      done_nxt = 1'b0; // RQ10
    end

    if (req.rd) begin
      if (req.sel == `IDX_CONTROL) begin
        rdata_nxt = {msel_r, csel_r, 1'b0, free_r, abort_r, gate_r, wr_r, rd_r};
      end else if (req.sel == `IDX_ADDR_LO) begin
        rdata_nxt = adl_r;
      end else if (req.sel == `IDX_ADDR_HI) begin
        rdata_nxt = {6'h00, adh_r};
      end else if (req.sel == `IDX_DATA) begin
        rdata_nxt = data_r;
      end else if (req.sel == `IDX_FLAGS2) begin
        rdata_nxt = {3'h0, done_r, 4'h0};
      end else begin
        rdata_nxt = 8'h00; // RQ14
      end
    end else begin
      rdata_nxt = rdata_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys) begin
    if (por) begin
      msel_r <= 1'b0;
      csel_r <= 1'b0;
      abort_r <= 1'b0;
      adl_r <= 8'h00;
      adh_r <= 2'h0;
      data_r <= 8'h00;
      gate_r <= 1'b0; // RQ6
    end else if (rst) begin
      // Selects kept for tracing an aborted write
      abort_r <= abort_r | wr_r; // RQ8 RQ15
      gate_r <= 1'b0;
    end else begin
      msel_r <= msel_nxt;
      csel_r <= csel_nxt;
      abort_r <= abort_nxt;
      adl_r <= adl_nxt;
      adh_r <= adh_nxt;
      data_r <= data_nxt;
      gate_r <= gate_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || por) begin
      free_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      tmr_r <= 32'h0;
      flash_r <= 1'b0;
      ext_r <= 1'b0;
      ws_r <= WS_IDLE;
      ul_r <= UL_IDLE;
    end else begin
      free_r <= free_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      tmr_r <= tmr_nxt;
      flash_r <= flash_nxt;
      ext_r <= ext_nxt;
      ws_r <= ws_nxt;
      ul_r <= ul_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem_r[addr] <= mem_wd;
    end
  end

  assign rdata = rdata_r;
  assign flash_start = flash_r;
  assign flash_row_erase = free_r;
  assign cfg_target = csel_r;
  assign busy = wr_r;

  ////////////////////////////////////////////////////////////////
  // Checks
  a_wr_needs_gate: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ19
    $rose(wr_r) |-> $past(gate_r))
    else $error("write started without gate");

  a_wr_needs_key: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ18
    $rose(wr_r) |-> $past(ul_r) == UL_KEY2)
    else $error("write started without unlock");

  a_abort_on_start: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ7
    $rose(wr_r) |-> abort_r throughout (wr_r [*2]))
    else $error("abort flag not set during write");

  a_done_on_end: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ10
    $fell(wr_r) && !$past(rst || por) |-> done_r && !abort_r && !free_r)
    else $error("completion flags wrong");

  a_rd_one_cycle: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ12
    rd_r && !go_rd |=> !rd_r)
    else $error("read start not self-cleared");

  a_rd_blocked: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ11
    sw && (req.wdata[`BIT_MSEL] || req.wdata[`BIT_CSEL]) |=> !rd_r)
    else $error("read started on wrong space");

  a_regs_frozen: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ20
    wr_r && ws_r != WS_PROG |=> $stable(adl_r) && $stable(data_r) && $stable(msel_r))
    else $error("register changed during write");

  a_pwrt_block: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ21
    pwrt_s2_r |=> !$rose(wr_r))
    else $error("write during power-up timer");

  a_unlock_zero: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ14
    req.rd && req.sel == `IDX_UNLOCK |=> rdata == 8'h00)
    else $error("unlock port not zero");

  a_wr_set_only: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ9
    wr_r && ws_r == WS_ERASE |=> wr_r)
    else $error("write start cleared early");

  a_gate_por_clear: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ6
    $past(por) |-> !gate_r)
    else $error("write gate set after power-on");

  a_reset_abort: assert property (@(posedge clk_sys) disable iff (por) // RQ8
    rst && wr_r |=> abort_r)
    else $error("abort flag lost on reset in write");

  a_reset_keeps_sel: assert property (@(posedge clk_sys) disable iff (por) // RQ15
    rst |=> msel_r == $past(msel_r) && csel_r == $past(csel_r))
    else $error("select bits changed by reset");

  a_refuse_abort: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ8
    ws_r == WS_IDLE && sw && req.wdata[`BIT_WR] && !go_wr |=> abort_r)
    else $error("refused write left abort clear");

  a_done_sticky: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ10
    done_r && !(req.wr && req.sel == `IDX_FLAGS2) |=> done_r)
    else $error("done flag dropped without clear");

  a_busy_until_end: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ9
    wr_r && !(ws_r == WS_PROG && tmr_r == 32'h0) |=> wr_r)
    else $error("write start cleared before completion");

  a_data_held: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ13
    !go_rd && !(req.wr && req.sel == `IDX_DATA) |=> $stable(data_r))
    else $error("data register changed without cause");

  a_flash_pulse: assert property (@(posedge clk_sys) disable iff (rst || por) // RQ1
    flash_start |=> !flash_start)
    else $error("flash start longer than one cycle");

endmodule

// >>> design/nvm_ctl_regs.svh
`ifndef NVM_CTL_REGS_SVH
`define NVM_CTL_REGS_SVH
// Contract
// [RQ1] Config select clear: memory select 0 targets EEPROM, 1 targets program flash.
// [RQ2] Config select set sends accesses to configuration registers.
// [RQ3] Address is 8-bit low plus two high bits, 1024 bytes.
// [RQ4] One 8-bit data register returns read data and supplies write data.
// [RQ5] Byte write erases then programs, self-timed by an internal counter.
// [RQ6] Writes only while write enable gate is 1; gate cleared at power-up.
// [RQ7] Abort flag set at write start, cleared when timer expires and write completes.
// [RQ8] Abort flag stays 1 after reset during programming or improper attempt.
// [RQ9] Write start is set-only by software, cleared by hardware at completion.
// [RQ10] Completion sets memory done flag, held until software clears it.
// [RQ11] Read start ignored while memory select or config select is 1.
// [RQ12] Read takes one cycle; read start self-clears; data ready next cycle.
// [RQ13] Data register keeps read value until next read or software write.
// [RQ14] Unlock port has no storage and reads as zero.
// [RQ15] Abort leaves memory and config select bits unchanged.
// [RQ16] Row erase bit set: next write erases flash block, completion clears it.
// [RQ17] Software loads address, clears memory select, then sets read start.
// [RQ18] Write starts only after 55h then 0AAh to unlock port, then write start.
// [RQ19] Write start blocked unless write enable gate was already set.
// [RQ20] During a write, control, address and data registers reject changes.
// [RQ21] EEPROM writes blocked during power-up timer period.
// [RQ22] Write duration is a parameter counted by a timer started at acceptance.

// Register indexes on the special function register port
`define IDX_CONTROL 3'h0
`define IDX_UNLOCK 3'h1
`define IDX_ADDR_LO 3'h2
`define IDX_ADDR_HI 3'h3
`define IDX_DATA 3'h4
`define IDX_FLAGS2 3'h5

// Control register fields; BIT_DONE is in the flags register
`define BIT_RD 0
`define BIT_WR 1
`define BIT_GATE 2
`define BIT_ABORT 3
`define BIT_FREE 4
`define BIT_CSEL 6
`define BIT_MSEL 7
`define BIT_DONE 4

`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'haa
`define ERASED_BYTE 8'hff

// Self-timed phases
`define CLK_PERIOD_NS 50
`define ERASE_TIME_NS 1000000
`define PROG_TIME_NS 1000000
`define ERASE_CYC ((`ERASE_TIME_NS) / (`CLK_PERIOD_NS))
`define PROG_CYC ((`PROG_TIME_NS) / (`CLK_PERIOD_NS))
`endif

// >>> design/nvm_ctl_pkg.sv
package nvm_ctl_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef enum logic [2:0] {
    WS_IDLE = 3'b001,
    WS_ERASE = 3'b010,
    WS_PROG = 3'b100
  } wr_state_t;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_KEY1 = 3'b010,
    UL_KEY2 = 3'b100
  } unlock_t;
endpackage

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`include "nvm_ctl_regs.svh"
module tb_top;
  import nvm_ctl_pkg::*;
  logic clk_sys;
  logic rst;
  logic por;
  logic pwrt_active;
  sfr_req_t req;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic flash_start;
  logic flash_row_erase;
  logic cfg_target;
  logic busy;
  int error_cnt;
  int n_tests;

  nvm_ctl #(.DEPTH(1024), .ERASE_CYC(4), .PROG_CYC(4)) dut_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .por(por),
    .pwrt_active(pwrt_active),
    .req(req),
    .rdata(rdata),
    .flash_start(flash_start),
    .flash_row_erase(flash_row_erase),
    .cfg_target(cfg_target),
    .busy(busy)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  // Register access: idle cycle, then one-cycle strobe 1 ns after the edge
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(posedge clk_sys);
    #1;
    req = '0;
  endtask

  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    req = '0;
    d = rdata;
  endtask

  task automatic unlock_go(input logic [7:0] c);
    wr(`IDX_UNLOCK, `UNLOCK_KEY1);
    wr(`IDX_UNLOCK, `UNLOCK_KEY2);
    wr(`IDX_CONTROL, c);
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 50) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    cmp1(busy, 1'b0, "busy stuck");
  endtask

  task automatic ee_write(input logic [9:0] a, input logic [7:0] d);
    wr(`IDX_ADDR_LO, a[7:0]);
    wr(`IDX_ADDR_HI, {6'h00, a[9:8]});
    wr(`IDX_DATA, d);
    wr(`IDX_CONTROL, 8'h04);
    unlock_go(8'h06);
    cmp1(busy, 1'b1, "write start");
    rd(`IDX_CONTROL, rv);
    cmp8(rv, 8'h0e, "ctrl while busy");
    // Changes while busy must be dropped
    wr(`IDX_DATA, ~d);
    wr(`IDX_CONTROL, 8'h00);
    cmp1(busy, 1'b1, "busy cleared by write");
    wait_idle;
    rd(`IDX_CONTROL, rv);
    cmp8(rv, 8'h04, "ctrl after write");
    rd(`IDX_FLAGS2, rv);
    cmp1(rv[`BIT_DONE], 1'b1, "done flag");
    wr(`IDX_FLAGS2, 8'h00);
    rd(`IDX_FLAGS2, rv);
    cmp1(rv[`BIT_DONE], 1'b0, "done clear");
  endtask

  task automatic ee_read(input logic [9:0] a, input logic [7:0] e);
    wr(`IDX_ADDR_LO, a[7:0]);
    wr(`IDX_ADDR_HI, {6'h00, a[9:8]});
    wr(`IDX_CONTROL, 8'h01);
    rd(`IDX_DATA, rv);
    cmp8(rv, e, "read data");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(5000 * 50);
    error_cnt++;
    end_sim;
  end

  initial begin
    rst = 1'b1;
    por = 1'b1;
    pwrt_active = 1'b0;
    req = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    por = 1'b0;
    rd(`IDX_CONTROL, rv);
    cmp8(rv, 8'h00, "ctrl after power-on");
    wr(`IDX_UNLOCK, 8'h55);
    rd(`IDX_UNLOCK, rv);
    cmp8(rv, 8'h00, "unlock port read");
    // Two locations differing only in the high address bits
    ee_write(10'h235, 8'h5a);
    ee_write(10'h035, 8'ha5);
    ee_read(10'h235, 8'h5a);
    ee_read(10'h035, 8'ha5);
    rd(`IDX_CONTROL, rv);
    cmp1(rv[`BIT_RD], 1'b0, "read start left set");
    rd(`IDX_DATA, rv);
    cmp8(rv, 8'ha5, "data held");
    // Read start refused while a select bit is set
    wr(`IDX_DATA, 8'h3c);
    wr(`IDX_CONTROL, 8'h81);
    rd(`IDX_DATA, rv);
    cmp8(rv, 8'h3c, "read with flash select");
    rd(`IDX_CONTROL, rv);
    cmp8(rv, 8'h80, "ctrl flash select");
    wr(`IDX_CONTROL, 8'h41);
    cmp1(cfg_target, 1'b1, "config target");
    rd(`IDX_CONTROL, rv);
    cmp8(rv, 8'h40, "ctrl config select");
    // Gate and start in one write
    wr(`IDX_CONTROL, 8'h00);
    unlock_go(8'h06);
    cmp1(busy, 1'b0, "start without gate");
    rd(`IDX_CONTROL, rv);
    cmp8(rv & 8'h0b, 8'h08, "abort on gate");
    // Broken unlock order
    wr(`IDX_CONTROL, 8'h04);
    wr(`IDX_UNLOCK, `UNLOCK_KEY1);
    wr(`IDX_DATA, 8'h11);
    wr(`IDX_UNLOCK, `UNLOCK_KEY2);
    wr(`IDX_CONTROL, 8'h06);
    cmp1(busy, 1'b0, "start after broken order");
    rd(`IDX_CONTROL, rv);
    cmp1(rv[`BIT_ABORT], 1'b1, "abort on order");
    // Flash target with row erase
    wr(`IDX_CONTROL, 8'h94);
    cmp1(flash_row_erase, 1'b1, "row erase level");
    unlock_go(8'h96);
    cmp1(flash_start, 1'b1, "flash start pulse");
    cmp1(busy, 1'b1, "flash busy");
    wait_idle;
    cmp1(flash_row_erase, 1'b0, "row erase after done");
    wr(`IDX_FLAGS2, 8'h00);
    // Reset in the erase phase of a flash write
    wr(`IDX_CONTROL, 8'h84);
    unlock_go(8'h86);
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b1;
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    rd(`IDX_CONTROL, rv);
    cmp8(rv, 8'h88, "ctrl after reset in write");
    // Power-up timer blocks writes
    wr(`IDX_CONTROL, 8'h04);
    pwrt_active = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    unlock_go(8'h06);
    cmp1(busy, 1'b0, "write in power-up time");
    pwrt_active = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    ee_write(10'h3ff, 8'hc3);
    ee_read(10'h3ff, 8'hc3);
    end_sim;
  end
endmodule
